// ### hw/low_power_pin_state_control.sv
// per-pin state selection across reset, standby, sleep and bus release
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`include "pin_state_map.svh"

//Behaviour
//R1 - software standby frees timer pin to port
//R2 - software standby floats bus-grant acknowledge pin
//R3 - software standby returns peripheral pins to port
//R4 - sleep in 2/4: address low, inputs float
//R5 - ports 5/6 pull-up when input, data one
//R6 - address low, strobe high two cycles later
//R7 - clock pins become outputs one cycle later
//R8 - pull-ups off in reset and hardware standby
//R9 - pin drive chosen from state, mode, bits
module low_power_pin_state_control
  import pin_state_pkg::*;
#(
  parameter int CNT_W = 3
)
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_res_n,
  input wire logic [2:0] i_mode,
  input op_state_t i_state,
  input func_t [`NPORT-1:0] i_func,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output pin_t [`NPORT-1:0] o_pins
);

  localparam logic [CNT_W-1:0] CLK_CYC = CNT_W'(`CLK_INIT_CYC);
  localparam logic [CNT_W-1:0] ADDR_CYC = CNT_W'(`ADDR_INIT_CYC);

  // ****************************************
  // pin classification
  // ****************************************
  function automatic logic full_addr(input logic [2:0] p, input logic [2:0] m);
    full_addr = (p == `PORT4_IDX && m != `MODE_7) || (p == `PORT5_IDX && (m == `MODE_1 || m == `MODE_3))
      || (p == `PORT6_IDX && m == `MODE_3);
  endfunction

  function automatic logic part_addr(input logic [2:0] p, input logic [2:0] m);
    part_addr = (p == `PORT5_IDX && (m == `MODE_2 || m == `MODE_4)) || (p == `PORT6_IDX && m == `MODE_4);
  endfunction

  function automatic logic pull_ok(input logic [2:0] p, input logic [2:0] m);
    pull_ok = (p == `PORT5_IDX && (m == `MODE_2 || m == `MODE_4 || m == `MODE_7))
      || (p == `PORT6_IDX && m != `MODE_3);
  endfunction

  function automatic pin_t decide(input logic [2:0] p, input logic [2:0] m, input op_state_t st,
                                  input logic [`PORT_W-1:0] ddr, input logic [`PORT_W-1:0] pdata, input func_t f);
    pin_t r;
    logic ext;
    logic strb;
    logic data;
    logic fa;
    logic pa;
    ext = m != `MODE_7;
    strb = ext && p == `PORT2_IDX;
    data = ext && p == `PORT3_IDX;
    fa = full_addr(p, m);
    pa = part_addr(p, m);
    r.oe = (f.en & f.oe) | (~f.en & ddr); // R9
    r.out = (f.en & f.out) | (~f.en & pdata); // R9
    r.pu = pull_ok(p, m) ? (~ddr & pdata) : '0; // R5
    unique case (st)
      OP_RESET:
      begin
        r = '0; // R8
        if (strb)
        begin
          r.oe = '1;
          r.out = '1;
        end
        if (fa)
        begin
          r.oe = '1;
        end
        if (p == `PORT1_IDX)
        begin
          r.oe = `CLK_MASK;
          r.out = f.out & `CLK_MASK;
        end
      end
      OP_HW_STBY:
      begin
        r = '0; // R8
      end
      OP_SW_STBY:
      begin
        // peripherals are reset, so the timer pin and the other peripheral pins fall back to plain port
        r.oe = ddr; // R1 R3
        r.out = pdata; // R1 R3
        if (strb || data || fa || pa)
        begin
          r.oe = '0;
        end
        if (p == `PORT1_IDX)
        begin
          r.oe[`BACK_BIT] = ddr[`BACK_BIT] & ~f.en[`BACK_BIT]; // R2
          if (ext)
          begin
            r.out = (pdata & ~`CLK_MASK) | `PHI_HIGH;
          end
          else
          begin
            r.oe = r.oe & ~`CLK_MASK;
          end
        end
      end
      OP_SLEEP:
      begin
        if (strb)
        begin
          r.oe = '1;
          r.out = '1;
        end
        if (data)
        begin
          r.oe = '0;
        end
        if (fa)
        begin
          r.oe = '1;
          r.out = '0;
        end
        if (pa)
        begin
          r.oe = ddr; // R4
          r.out = '0; // R4
        end
      end
      OP_BUS_REL:
      begin
        if (strb || data || fa || pa)
        begin
          r.oe = '0;
        end
      end
      OP_RUN:
      begin
        if (strb || data || fa)
        begin
          r.oe = f.oe; // R9
          r.out = f.out;
        end
        if (pa)
        begin
          r.oe = ddr; // R9
          r.out = f.out;
        end
      end
      default:
      begin
        r = '0;
      end
    endcase
    decide = r;
  endfunction

  // ****************************************
  // effective state and reset counter
  // ****************************************
  op_state_t eff;
  logic [CNT_W-1:0] rcnt_q;
  logic [CNT_W-1:0] rcnt_d;

  always_comb
  begin
    if (i_state == OP_HW_STBY)
    begin
      eff = OP_HW_STBY;
    end
    else if (!i_res_n)
    begin
      eff = OP_RESET;
    end
    else
    begin
      eff = i_state;
    end
    rcnt_d = '0;
    if (eff == OP_RESET)
    begin
      rcnt_d = (rcnt_q == ADDR_CYC) ? rcnt_q : rcnt_q + CNT_W'(1); // R6 R7
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      rcnt_q <= '0;
    end
    else
    begin
      rcnt_q <= rcnt_d;
    end
  end

  // ****************************************
  // register slave
  // ****************************************
  logic [`PORT_W-1:0] ddr_q [`NPORT];
  logic [`PORT_W-1:0] ddr_d [`NPORT];
  logic [`PORT_W-1:0] pdata_q [`NPORT];
  logic [`PORT_W-1:0] pdata_d [`NPORT];
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [2:0] ridx;
  logic sel_ddr;
  logic sel_pdata;

  always_comb
  begin
    ridx = i_avs_address[`REG_IDX_MSB:`REG_IDX_LSB];
    sel_ddr = (i_avs_address & `REG_GRP_MASK) == `REG_DDR_BASE;
    sel_pdata = (i_avs_address & `REG_GRP_MASK) == `REG_PDATA_BASE;
    // one wait state: the answer is formed while waitrequest is high
    ack_d = (i_avs_read || i_avs_write) && !ack_q;
    rdata_d = rdata_q;
    if (i_avs_read && !ack_q)
    begin
      if (sel_ddr)
      begin
        rdata_d = 32'(ddr_q[ridx]);
      end
      else if (sel_pdata)
      begin
        rdata_d = 32'(pdata_q[ridx]);
      end
      else if (i_avs_address == `REG_STATUS)
      begin
        rdata_d = 32'(i_mode) | (32'(eff) << `STAT_STATE_LSB) | (32'(rcnt_q) << `STAT_CNT_LSB);
      end
      else
      begin
        rdata_d = '0;
      end
    end
    ddr_d = ddr_q;
    pdata_d = pdata_q;
    if (eff == OP_RESET)
    begin
      ddr_d = '{default: '0};
      pdata_d = '{default: '0};
    end
    else if (i_avs_write && ack_q && i_avs_byteenable[0])
    begin
      if (sel_ddr)
      begin
        ddr_d[ridx] = i_avs_writedata[`PORT_W-1:0];
      end
      if (sel_pdata)
      begin
        pdata_d[ridx] = i_avs_writedata[`PORT_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      ack_q <= 1'b0;
      rdata_q <= '0;
      ddr_q <= '{default: '0};
      pdata_q <= '{default: '0};
    end
    else
    begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      ddr_q <= ddr_d;
      pdata_q <= pdata_d;
    end
  end

  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;
  assign o_avs_readdata = rdata_q;

  // ****************************************
  // per-port selection
  // ****************************************
  for (genvar g = 0; g < `NPORT; g++)
  begin : g_port
    localparam logic [2:0] PIDX = 3'(g);
    pin_t nxt;
    logic [`PORT_W-1:0] hold;

    always_comb
    begin
      nxt = decide(PIDX, i_mode, eff, ddr_q[g], pdata_q[g], i_func[g]);
      hold = '0;
      if (eff == OP_RESET)
      begin
        // full address lines and the RW strobe bit of port 2 keep their last level until the counter expires
        if (PIDX == `PORT1_IDX && rcnt_q < CLK_CYC)
        begin
          hold = `CLK_MASK; // R7
        end
        if (full_addr(PIDX, i_mode) && rcnt_q < ADDR_CYC)
        begin
          hold = '1; // R6
        end
        if (PIDX == `PORT2_IDX && i_mode != `MODE_7 && rcnt_q < ADDR_CYC)
        begin
          hold = `RW_MASK; // R6
        end
      end
    end

    pin_state_cell u_cell (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_hold(hold),
      .i_next(nxt),
      .o_pin(o_pins[g])
    );
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_res_start;
    $fell(i_res_n) && i_state != OP_HW_STBY && i_mode != `MODE_7;
  endsequence

  sequence s_res_on;
    !i_res_n && i_state != OP_HW_STBY;
  endsequence

  property p_timer_port;
    @(posedge i_clock) disable iff (i_reset)
    eff == OP_SW_STBY |=> o_pins[`PORT1_IDX].oe[`TIMER_BIT] == $past(ddr_q[`PORT1_IDX][`TIMER_BIT])
      && o_pins[`PORT1_IDX].out[`TIMER_BIT] == $past(pdata_q[`PORT1_IDX][`TIMER_BIT]);
  endproperty
  a_timer_port: assert property (p_timer_port) else $error("timer pin not plain port in standby"); // R1

  property p_back_float;
    @(posedge i_clock) disable iff (i_reset)
    eff == OP_SW_STBY && i_func[`PORT1_IDX].en[`BACK_BIT] |=> !o_pins[`PORT1_IDX].oe[`BACK_BIT];
  endproperty
  a_back_float: assert property (p_back_float) else $error("acknowledge pin driven in standby"); // R2

  property p_periph_port;
    @(posedge i_clock) disable iff (i_reset)
    eff == OP_SW_STBY |=> o_pins[`PORT9_IDX].oe == $past(ddr_q[`PORT9_IDX])
      && o_pins[`PORT7_IDX].out == $past(pdata_q[`PORT7_IDX]);
  endproperty
  a_periph_port: assert property (p_periph_port) else $error("peripheral pin not plain port in standby"); // R3

  property p_sleep_addr;
    @(posedge i_clock) disable iff (i_reset)
    eff == OP_SLEEP && (i_mode == `MODE_2 || i_mode == `MODE_4)
      |=> o_pins[`PORT5_IDX].oe == $past(ddr_q[`PORT5_IDX]) && o_pins[`PORT5_IDX].out == '0;
  endproperty
  a_sleep_addr: assert property (p_sleep_addr) else $error("sleep address pins wrong"); // R4

  property p_pullup;
    @(posedge i_clock) disable iff (i_reset)
    eff == OP_RUN && i_mode == `MODE_2
      |=> o_pins[`PORT5_IDX].pu == $past(~ddr_q[`PORT5_IDX] & pdata_q[`PORT5_IDX]);
  endproperty
  a_pullup: assert property (p_pullup) else $error("port pull-up wrong"); // R5

  property p_addr_hold;
    @(posedge i_clock) disable iff (i_reset)
    s_res_start ##1 s_res_on |=> $stable(o_pins[`PORT4_IDX]);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address lines changed too early"); // R6

  property p_addr_init;
    @(posedge i_clock) disable iff (i_reset)
    s_res_start ##1 s_res_on [*2] |=> o_pins[`PORT4_IDX].oe == '1 && o_pins[`PORT4_IDX].out == '0
      && (o_pins[`PORT2_IDX].out & `RW_MASK) == `RW_MASK;
  endproperty
  a_addr_init: assert property (p_addr_init) else $error("address lines not low after reset delay"); // R6

  property p_clk_hold;
    @(posedge i_clock) disable iff (i_reset)
    s_res_start |=> $stable(o_pins[`PORT1_IDX].oe & `CLK_MASK);
  endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("clock pins changed too early"); // R7

  property p_clk_init;
    @(posedge i_clock) disable iff (i_reset)
    s_res_start ##1 s_res_on |=> (o_pins[`PORT1_IDX].oe & `CLK_MASK) == `CLK_MASK;
  endproperty
  a_clk_init: assert property (p_clk_init) else $error("clock pins not outputs after reset delay"); // R7

  property p_pull_off;
    @(posedge i_clock) disable iff (i_reset)
    (eff == OP_RESET || eff == OP_HW_STBY) |=> o_pins[`PORT5_IDX].pu == '0 && o_pins[`PORT6_IDX].pu == '0;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull-up on in reset or hardware standby"); // R8

  property p_run_select;
    @(posedge i_clock) disable iff (i_reset)
    eff == OP_RUN |=> o_pins[`PORT9_IDX].oe
      == $past((i_func[`PORT9_IDX].en & i_func[`PORT9_IDX].oe) | (~i_func[`PORT9_IDX].en & ddr_q[`PORT9_IDX]));
  endproperty
  a_run_select: assert property (p_run_select) else $error("running pin selection wrong"); // R9

endmodule

// ### hw/pin_state_cell.sv
// output register of one port with per-bit hold
`include "pin_state_map.svh"
module pin_state_cell
  import pin_state_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [`PORT_W-1:0] i_hold,
  input pin_t i_next,
  output pin_t o_pin
);

  pin_t pin_q;
  pin_t pin_d;

  // ****************************************
  // next value
  // ****************************************
  always_comb
  begin
    pin_d.oe = (i_hold & pin_q.oe) | (~i_hold & i_next.oe);
    pin_d.out = (i_hold & pin_q.out) | (~i_hold & i_next.out);
    pin_d.pu = (i_hold & pin_q.pu) | (~i_hold & i_next.pu);
  end

  // ****************************************
  // register
  // ****************************************
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      pin_q <= '0;
    end
    else
    begin
      pin_q <= pin_d;
    end
  end

  assign o_pin = pin_q;

endmodule

// ### hw/pin_state_map.svh
// constant map for the low-power pin state controller
`ifndef PIN_STATE_MAP_SVH
`define PIN_STATE_MAP_SVH

// ****************************************
// port geometry
// ****************************************
`define PORT_W 8
`define NPORT 8
`define PORT1_IDX 3'h0
`define PORT2_IDX 3'h1
`define PORT3_IDX 3'h2
`define PORT4_IDX 3'h3
`define PORT5_IDX 3'h4
`define PORT6_IDX 3'h5
`define PORT7_IDX 3'h6
`define PORT9_IDX 3'h7

// ****************************************
// operating modes
// ****************************************
`define MODE_1 3'h1
`define MODE_2 3'h2
`define MODE_3 3'h3
`define MODE_4 3'h4
`define MODE_7 3'h7

// ****************************************
// special pin positions
// ****************************************
`define CLK_MASK 8'h03
`define PHI_HIGH 8'h01
`define BACK_BIT 2
`define TIMER_BIT 7
`define RW_MASK 8'h08

// ****************************************
// reset timing
// ****************************************
`define CLK_PERIOD_NS 100
`define CLK_INIT_NS 50
`define ADDR_INIT_NS 150
`define CLK_INIT_CYC ((`CLK_INIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_INIT_CYC ((`ADDR_INIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ****************************************
// register map
// ****************************************
`define REG_GRP_MASK 8'he0
`define REG_DDR_BASE 8'h00
`define REG_PDATA_BASE 8'h20
`define REG_STATUS 8'h40
`define REG_IDX_MSB 4
`define REG_IDX_LSB 2
`define STAT_STATE_LSB 4
`define STAT_CNT_LSB 8

`endif

// ### hw/pin_state_pkg.sv
// types shared by the pin state controller
`include "pin_state_map.svh"

package pin_state_pkg;

  // ****************************************
  // operating states
  // ****************************************
  typedef enum logic [2:0] {
    OP_RUN,
    OP_SLEEP,
    OP_SW_STBY,
    OP_HW_STBY,
    OP_BUS_REL,
    OP_RESET
  } op_state_t;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [`PORT_W-1:0] en;
    logic [`PORT_W-1:0] oe;
    logic [`PORT_W-1:0] out;
  } func_t;

  typedef struct packed {
    logic [`PORT_W-1:0] oe;
    logic [`PORT_W-1:0] out;
    logic [`PORT_W-1:0] pu;
  } pin_t;

endpackage

// ### verif/low_power_pin_state_control_tb.sv
// self-checking bench for the low-power pin state controller
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module low_power_pin_state_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pin_state_pkg::*;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_res_n = 1'b1;
  logic [2:0] i_mode = 3'h7;
  op_state_t i_state = OP_RUN;
  func_t [7:0] i_func = '0;
  logic [7:0] i_avs_address = 8'h00;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [3:0] i_avs_byteenable = 4'h1;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  pin_t [7:0] o_pins;
  logic [7:0][7:0] level;
  int errors = 0;
  int n_compared = 0;
  logic [31:0] q;

  low_power_pin_state_control #(.CNT_W(3)) i_dut (.i_clock(i_clock), .i_reset(i_reset), .i_res_n(i_res_n),
    .i_mode(i_mode), .i_state(i_state), .i_func(i_func), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_pins(o_pins));
  pin_world_model i_world (.i_clock(i_clock), .i_pins(o_pins), .o_level(level));

  initial
  begin
    forever #50 i_clock = ~i_clock;
  end

  // ****************************************
  // bus and timing helpers
  // ****************************************
  // the master never assumes the wait-state count; it waits until waitrequest is low, and only the watchdog ends a hung wait
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge i_clock);
    i_avs_address <= a;
    i_avs_write <= wr;
    i_avs_read <= ~wr;
    i_avs_writedata <= {24'h0, d};
    i_avs_byteenable <= be;
    do
    begin
      @(posedge i_clock);
    end
    while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00, 4'h1);
    `CHK(q, e)
  endtask
  task automatic settle();
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
  endtask
  // mode is only changed under reset, as the core would
  task automatic set_mode(input logic [2:0] m);
    @(posedge i_clock);
    i_reset <= 1'b1;
    i_mode <= m;
    i_state <= OP_RUN;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge i_clock);
    errors++;
    give_verdict();
  end

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (5) @(posedge i_clock);
    i_reset <= 1'b0;
    @(negedge i_clock);
    `CHK(o_pins, '0)
    wr(8'h18, 8'hff);
    wr(8'h38, 8'ha5);
    rdc(8'h18, 32'hff);
    rdc(8'h60, 32'h0);
    rdc(8'h40, 32'h07);
    bus(1'b1, 8'h38, 8'h00, 4'h0);
    rdc(8'h38, 32'ha5);
    settle();
    `CHK(o_pins[6].oe, 8'hff)
    `CHK(o_pins[6].out, 8'ha5)
    wr(8'h10, 8'h0f);
    wr(8'h30, 8'hff);
    wr(8'h34, 8'h3c);
    settle();
    `CHK(o_pins[4].pu, 8'hf0)
    `CHK(o_pins[5].pu, 8'h3c)
    `CHK(level[4][7:4], 4'hf)
    // peripherals own port 7 and the timer pin; standby must hand both back to the port bits
    @(posedge i_clock);
    i_func[6] <= {8'hff, 8'hff, 8'h00};
    i_func[0] <= {8'h80, 8'h80, 8'h80};
    settle();
    `CHK(o_pins[0].oe[7], 1'b1)
    `CHK(o_pins[6].out, 8'h00)
    @(posedge i_clock);
    i_state <= OP_SW_STBY;
    settle();
    `CHK(o_pins[0].oe[7], 1'b0)
    `CHK(o_pins[6].oe, 8'hff)
    `CHK(o_pins[6].out, 8'ha5)
    `CHK(o_pins[4].pu, 8'hf0)
    @(posedge i_clock);
    i_state <= OP_HW_STBY;
    settle();
    `CHK(o_pins[4].pu, 8'h00)
    `CHK(o_pins[6].oe, 8'h00)
    set_mode(3'h2);
    i_func[0] <= {8'h04, 8'h04, 8'h00};
    i_func[6] <= '0;
    wr(8'h10, 8'hf0);
    wr(8'h30, 8'h0f);
    // acknowledge pin is a port output too, so only its function flag can float it
    wr(8'h00, 8'h04);
    settle();
    `CHK(o_pins[0].oe[2], 1'b1)
    @(posedge i_clock);
    i_state <= OP_SW_STBY;
    settle();
    `CHK(o_pins[0].oe[2], 1'b0)
    @(posedge i_clock);
    i_state <= OP_SLEEP;
    settle();
    `CHK(o_pins[4].oe, 8'hf0)
    `CHK(o_pins[4].out & 8'hf0, 8'h00)
    `CHK(o_pins[4].pu, 8'h0f)
    `CHK(o_pins[3].oe, 8'hff)
    `CHK(o_pins[3].out, 8'h00)
    @(posedge i_clock);
    i_state <= OP_BUS_REL;
    settle();
    `CHK(o_pins[1].oe, 8'h00)
    `CHK(o_pins[3].oe, 8'h00)
    `CHK(o_pins[4].oe, 8'h00)
    set_mode(3'h3);
    i_state <= OP_SLEEP;
    settle();
    `CHK(o_pins[5].oe, 8'hff)
    `CHK(o_pins[5].out, 8'h00)
    set_mode(3'h4);
    i_state <= OP_SLEEP;
    wr(8'h14, 8'h0f);
    wr(8'h34, 8'hf0);
    settle();
    `CHK(o_pins[5].oe, 8'h0f)
    `CHK(o_pins[5].out, 8'h00)
    `CHK(o_pins[5].pu, 8'hf0)
    set_mode(3'h1);
    i_func <= '0;
    settle();
    @(posedge i_clock);
    i_res_n <= 1'b0;
    @(posedge i_clock);
    @(negedge i_clock);
    `CHK(o_pins[0].oe[1:0], 2'b00)
    `CHK(o_pins[2].oe, 8'h00)
    @(negedge i_clock);
    `CHK(o_pins[0].oe[1:0], 2'b11)
    `CHK(o_pins[3].oe, 8'h00)
    @(negedge i_clock);
    `CHK(o_pins[3].oe, 8'hff)
    `CHK(o_pins[3].out, 8'h00)
    `CHK({o_pins[1].oe[3], o_pins[1].out[3]}, 2'b11)
    `CHK(o_pins[4].pu, 8'h00)
    wr(8'h10, 8'hff);
    rdc(8'h10, 32'h0);
    bus(1'b0, 8'h40, 8'h00, 4'h1);
    `CHK(q[6:0], 7'h51)
    i_res_n <= 1'b1;
    settle();
    give_verdict();
  end
endmodule

// ### verif/pin_world_model.sv
// board side of the port pins: resolves each pin to the level a probe would see
module pin_world_model
  import pin_state_pkg::*;
(
  input wire logic i_clock,
  input pin_t [7:0] i_pins,
  output logic [7:0][7:0] o_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0][7:0] last_q = '0;
  // ****************************************
  // wire level
  // ****************************************
  // a floating pin without pull-up flips every cycle, so a stale value never passes for a driven one
  always_comb
  begin
    for (int p = 0; p < 8; p++)
    begin
      o_level[p] = (i_pins[p].oe & i_pins[p].out) | (~i_pins[p].oe & i_pins[p].pu)
                 | (~i_pins[p].oe & ~i_pins[p].pu & ~last_q[p]);
    end
  end
  always_ff @(posedge i_clock)
  begin
    last_q <= o_level;
  end
endmodule
